// File: design/pvi_cfg.svh
// constants of the parallel video input port: offsets, fields, resets, timing
`ifndef PVI_CFG_SVH
`define PVI_CFG_SVH

// ==========================================================
// register byte offsets
`define PVI_OFS_CTRL 8'h00
`define PVI_OFS_HSTART 8'h04
`define PVI_OFS_HACT 8'h08
`define PVI_OFS_VSTART 8'h0C
`define PVI_OFS_VACT 8'h10
`define PVI_OFS_STATUS 8'h14
`define PVI_OFS_SIZE 8'h18
`define PVI_OFS_PERIOD 8'h1C
`define PVI_OFS_FRAMES 8'h20

// ==========================================================
// field layout
`define PVI_CTRL_W 10
`define PVI_WIN_W 12
`define PVI_SIZE_H_LSB 16
`define PVI_ST_EYE 0
`define PVI_ST_MASK 1
`define PVI_ST_SIZE_OK 2
`define PVI_ST_RATE_OK 3
`define PVI_ST_SCALE_LSB 4
`define PVI_ST_RUN 6
`define PVI_ST_LOST 7

// ==========================================================
// reset values: rising capture edge, active high syncs and mask, strobe in use
`define PVI_CTRL_RST 10'h080
`define PVI_HSTART_RST 12'h000
`define PVI_HACT_RST 12'h780
`define PVI_VSTART_RST 12'h000
`define PVI_VACT_RST 12'h438

// ==========================================================
// accepted source sizes
`define PVI_W_FULL 12'd1920
`define PVI_H_FULL 12'd1080
`define PVI_W_HALF 12'd960
`define PVI_H_HALF 12'd540
`define PVI_W_720P 12'd1280
`define PVI_H_720P 12'd720

// ==========================================================
// timing: system clock and frame rates in millihertz
`define PVI_CLK_HZ 20000000
`define PVI_RATE_2D_MIN_MHZ 5000
`define PVI_RATE_2D_MAX_MHZ 62000
`define PVI_RATE_3D_MIN_MHZ 94500
`define PVI_RATE_3D720_MIN_MHZ 98000
`define PVI_RATE_3D_MAX_MHZ 122000
// shortest frame period rounds up, longest rounds down
`define PVI_CYC_UP(mhz) (32'((64'(`PVI_CLK_HZ) * 64'd1000 + 64'(mhz) - 64'd1) / 64'(mhz)))
`define PVI_CYC_DN(mhz) (32'((64'(`PVI_CLK_HZ) * 64'd1000) / 64'(mhz)))

`endif

// File: design/pvi_pad.sv
// holds no logic

// File: design/pvi_pkg.sv
// types shared by the parallel video input port
package pvi_pkg;

    // ==========================================================
    // enumerations
    typedef enum logic [1:0] {
        PVI_FMT_888 = 2'b00,
        PVI_FMT_666 = 2'b01,
        PVI_FMT_565 = 2'b10,
        PVI_FMT_422 = 2'b11
    } pvi_fmt_t;

    typedef enum logic [1:0] {
        PVI_SCL_NONE = 2'b00,
        PVI_SCL_H2 = 2'b01,
        PVI_SCL_V2 = 2'b10,
        PVI_SCL_1P5 = 2'b11
    } pvi_scale_t;

    typedef enum logic [1:0] {
        PVI_ST_IDLE = 2'b00,
        PVI_ST_SEEK = 2'b01,
        PVI_ST_RUN = 2'b10
    } pvi_fsm_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic glasses_en;
        logic mode_3d;
        logic use_de;
        logic mask_low;
        logic cap_fall;
        logic hs_low;
        logic vs_low;
        logic enable;
        pvi_fmt_t fmt;
    } pvi_ctrl_t;

    typedef struct packed {
        logic valid;
        logic sof;
        logic sol;
        logic eye;
        logic [23:0] data;
    } pvi_pix_t;

    typedef struct packed {
        logic pclk;
        logic fs;
        logic ls;
        logic de;
        logic eye;
        logic mask;
        logic [23:0] bus;
    } pvi_pins_t;

endpackage

// File: design/pvi_port.sv
// parallel video input port: pin capture, framing, format unpack and apb registers
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`include "pvi_cfg.svh"

// Operation
// - 2D accepts 1080p, 720p at 5-62 Hz
// - 3D accepts half sizes and 720p ranges
// - eye select marks each 3D frame
// - reduced 3D sizes flagged for upscaling
// - display frame paced by input frames
// - optional glasses sync follows eye
// - 24-bit 888 format on 24 wires
// - 18-bit 666 format on 18 wires
// - 16-bit 565 format on 16 wires
// - 16-bit 4:2:2 with even-sited chroma
// - frame, line, valid, 24-bit data, clock
// - sync polarities and capture edge programmable
// - auto window from pixel, line counts
// - mask blocks frames, keeps displayed image
// - mask polarity programmable, active high default
// - capture on rising edge after reset
module pvi_port #(
    parameter int PER_W = 23,
    parameter int unsigned P2D_LO = `PVI_CYC_UP(`PVI_RATE_2D_MAX_MHZ),
    parameter int unsigned P2D_HI = `PVI_CYC_DN(`PVI_RATE_2D_MIN_MHZ),
    parameter int unsigned P3D_LO = `PVI_CYC_UP(`PVI_RATE_3D_MAX_MHZ),
    parameter int unsigned P3D_HI = `PVI_CYC_DN(`PVI_RATE_3D_MIN_MHZ),
    parameter int unsigned P3D720_HI = `PVI_CYC_DN(`PVI_RATE_3D720_MIN_MHZ)
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // video pins
    input wire logic pix_clk,
    input wire logic frame_sync,
    input wire logic line_sync,
    input wire logic pixel_valid_in,
    input wire logic [23:0] pixel_bus,
    input wire logic eye_select,
    input wire logic frame_update_mask,
    // display side
    output pvi_pkg::pvi_pix_t pix_out,
    output logic disp_frame,
    output logic frame_hold,
    output pvi_pkg::pvi_scale_t scale_mode,
    output logic glasses_sync
);
    import pvi_pkg::*;

    // ==========================================================
    // parameter checks
    if (PER_W < 2 || PER_W > 31) begin : g_chk_w
        $error("period counter width out of range");
    end
    if (P2D_HI >= (32'd1 << PER_W) || P2D_LO >= P2D_HI || P3D_LO >= P3D_HI || P3D_LO >= P3D720_HI) begin : g_chk_p
        $error("frame period limits do not fit");
    end

    localparam logic [PER_W-1:0] PER_MAX = PER_W'(P2D_HI);

    typedef struct packed {
        pvi_fsm_t st;
        pvi_ctrl_t ctrl;
        logic [`PVI_WIN_W-1:0] hstart, hact, vstart, vact;
        logic [31:0] prdata;
        logic pclk_d;
        logic vs_d;
        logic hs_d;
        logic [`PVI_WIN_W-1:0] hcnt, vcnt, line_pix, line_cnt, meas_w, meas_h;
        logic [PER_W-1:0] per_cnt;
        logic [PER_W-1:0] period;
        logic lost;
        logic [31:0] frames;
        logic eye;
        logic mask_lat;
        logic sof_pend;
        logic cphase;
        logic [7:0] cb_hold;
        logic [7:0] cr_hold;
        logic size_ok;
        logic rate_ok;
        pvi_scale_t scale;
        pvi_pix_t pix;
        logic disp_frame;
    } pvi_state_t;

    pvi_state_t s;
    pvi_state_t next_s;
    pvi_pins_t pin_raw;
    pvi_pins_t pin;

    // ==========================================================
    // pin capture: every pin level, pixel clock included, crosses two flops
    assign pin_raw = '{pclk: pix_clk, fs: frame_sync, ls: line_sync, de: pixel_valid_in,
                       eye: eye_select, mask: frame_update_mask, bus: pixel_bus};

    pvi_sync2 #(
        .W($bits(pvi_pins_t))
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_raw),
        .q(pin)
    );

    // ==========================================================
    // pin unpacking into 8-bit components, comp2 high, comp0 low
    function automatic logic [23:0] pvi_unpack(input pvi_fmt_t fmt, input logic [23:0] b,
                                                input logic odd, input logic [7:0] cb, input logic [7:0] cr);
        logic [23:0] r;
        r = b;
        unique case (fmt)
            PVI_FMT_888: r = b;
            PVI_FMT_666: r = {b[17:12], b[17:16], b[11:6], b[11:10], b[5:0], b[5:4]};
            PVI_FMT_565: r = {b[15:11], b[15:13], b[10:5], b[10:9], b[4:0], b[4:2]};
            PVI_FMT_422: r = odd ? {b[7:0], b[15:8], cb} : {cr, b[15:8], b[7:0]};
        endcase
        return r;
    endfunction

    // ==========================================================
    // decoded capture-time terms
    logic cap, vs, hs, vs_lead, hs_lead, mask_now, mlat, ev, win, accept, cp, hit;
    logic [`PVI_WIN_W-1:0] hidx, vidx, lp;
    logic [`PVI_WIN_W:0] hend, vend;
    logic [31:0] per32, rd_val, stat;
    logic is_full, is_720, is_hh, is_hw, size_ok_v, rate_ok_v;
    pvi_scale_t scale_v;

    // capture edge from the synchronised pixel clock and its delayed copy
    always_comb begin
        cap = s.ctrl.cap_fall ? (s.pclk_d & ~pin.pclk) : (~s.pclk_d & pin.pclk);
        vs = pin.fs ^ s.ctrl.vs_low;
        hs = pin.ls ^ s.ctrl.hs_low;
        vs_lead = vs & ~s.vs_d;
        hs_lead = hs & ~s.hs_d;
        mask_now = pin.mask ^ s.ctrl.mask_low;
        // mask only acts from a frame boundary, since it may only move in blanking
        mlat = vs_lead ? mask_now : s.mask_lat;
        ev = vs_lead ? pin.eye : s.eye;
        hidx = hs_lead ? '0 : s.hcnt + 1'b1;
        vidx = vs_lead ? '0 : (hs_lead ? s.vcnt + 1'b1 : s.vcnt);
        lp = (hs_lead || vs_lead) ? '0 : s.line_pix;
        cp = hs_lead ? 1'b0 : s.cphase;
        hend = {1'b0, s.hstart} + {1'b0, s.hact};
        vend = {1'b0, s.vstart} + {1'b0, s.vact};
        // without the strobe the window is counted from the syncs
        if (s.ctrl.use_de) begin
            win = pin.de;
        end else begin
            win = (hidx >= s.hstart) && ({1'b0, hidx} < hend) &&
                  (vidx >= s.vstart) && ({1'b0, vidx} < vend);
        end
        accept = (s.st == PVI_ST_RUN) && win && !mlat;
    end

    // size and rate class of the frame that just ended
    always_comb begin
        per32 = 32'(s.per_cnt);
        is_full = (s.meas_w == `PVI_W_FULL) && (s.line_cnt == `PVI_H_FULL);
        is_720 = (s.meas_w == `PVI_W_720P) && (s.line_cnt == `PVI_H_720P);
        is_hh = (s.meas_w == `PVI_W_FULL) && (s.line_cnt == `PVI_H_HALF);
        is_hw = (s.meas_w == `PVI_W_HALF) && (s.line_cnt == `PVI_H_FULL);
        if (s.ctrl.mode_3d) begin
            size_ok_v = is_hh || is_hw || is_720;
            rate_ok_v = (per32 >= P3D_LO) && (is_720 ? per32 <= P3D720_HI : per32 <= P3D_HI);
        end else begin
            size_ok_v = is_full || is_720;
            rate_ok_v = (per32 >= P2D_LO) && (per32 <= P2D_HI) && !s.lost;
        end
        // reduced sizes are scaled to the full panel downstream
        if (is_hh) begin
            scale_v = PVI_SCL_V2;
        end else if (is_hw) begin
            scale_v = PVI_SCL_H2;
        end else if (is_720) begin
            scale_v = PVI_SCL_1P5;
        end else begin
            scale_v = PVI_SCL_NONE;
        end
    end

    // ==========================================================
    // register read mux
    always_comb begin
        stat = '0;
        stat[`PVI_ST_EYE] = s.eye;
        stat[`PVI_ST_MASK] = mask_now;
        stat[`PVI_ST_SIZE_OK] = s.size_ok;
        stat[`PVI_ST_RATE_OK] = s.rate_ok;
        stat[`PVI_ST_SCALE_LSB +: 2] = s.scale;
        stat[`PVI_ST_RUN] = (s.st == PVI_ST_RUN);
        stat[`PVI_ST_LOST] = s.lost;
        hit = 1'b1;
        unique case (paddr)
            `PVI_OFS_CTRL: rd_val = 32'(s.ctrl);
            `PVI_OFS_HSTART: rd_val = 32'(s.hstart);
            `PVI_OFS_HACT: rd_val = 32'(s.hact);
            `PVI_OFS_VSTART: rd_val = 32'(s.vstart);
            `PVI_OFS_VACT: rd_val = 32'(s.vact);
            `PVI_OFS_STATUS: rd_val = stat;
            `PVI_OFS_SIZE: rd_val = (32'(s.meas_h) << `PVI_SIZE_H_LSB) | 32'(s.meas_w);
            `PVI_OFS_PERIOD: rd_val = 32'(s.period);
            `PVI_OFS_FRAMES: rd_val = s.frames;
            default: begin
                rd_val = '0;
                hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.pix.valid = 1'b0;
        next_s.pix.sof = 1'b0;
        next_s.pix.sol = 1'b0;
        next_s.disp_frame = 1'b0;
        next_s.pclk_d = pin.pclk;

        // apb: read data is loaded in the setup cycle so the access phase shows a flop
        if (psel && !penable) begin
            next_s.prdata = rd_val;
        end
        if (psel && penable && pwrite) begin
            unique case (paddr)
                `PVI_OFS_CTRL: next_s.ctrl = pvi_ctrl_t'(pwdata[`PVI_CTRL_W-1:0]);
                `PVI_OFS_HSTART: next_s.hstart = pwdata[`PVI_WIN_W-1:0];
                `PVI_OFS_HACT: next_s.hact = pwdata[`PVI_WIN_W-1:0];
                `PVI_OFS_VSTART: next_s.vstart = pwdata[`PVI_WIN_W-1:0];
                `PVI_OFS_VACT: next_s.vact = pwdata[`PVI_WIN_W-1:0];
                default: ;
            endcase
        end

        // frame period in system cycles; stalling at the longest legal period marks lost syncs
        if (s.per_cnt != PER_MAX) begin
            next_s.per_cnt = s.per_cnt + 1'b1;
        end else begin
            next_s.lost = 1'b1;
        end

        unique case (s.st)
            PVI_ST_IDLE: begin
                if (s.ctrl.enable) begin
                    next_s.st = PVI_ST_SEEK;
                end
            end
            PVI_ST_SEEK: begin
                if (!s.ctrl.enable) begin
                    next_s.st = PVI_ST_IDLE;
                end else if (cap && vs_lead) begin
                    next_s.st = PVI_ST_RUN;
                end
            end
            PVI_ST_RUN: begin
                if (!s.ctrl.enable) begin
                    next_s.st = PVI_ST_IDLE;
                end
            end
            default: next_s.st = PVI_ST_IDLE;
        endcase

        if (s.st != PVI_ST_IDLE && cap) begin
            next_s.vs_d = vs;
            next_s.hs_d = hs;
            next_s.hcnt = hidx;
            next_s.vcnt = vidx;
            next_s.line_pix = lp;
            next_s.cphase = cp;
            // a line that carried pixels closes at the next line sync; the last line of a frame is cleared uncounted at the frame sync
            if (hs_lead && s.line_pix != '0) begin
                next_s.line_cnt = s.line_cnt + 1'b1;
                next_s.meas_w = s.line_pix;
            end
            if (vs_lead) begin
                next_s.meas_h = s.line_cnt;
                next_s.line_cnt = '0;
                next_s.period = s.per_cnt;
                next_s.per_cnt = '0;
                next_s.lost = (s.per_cnt == PER_MAX);
                next_s.eye = pin.eye;
                next_s.mask_lat = mask_now;
                next_s.sof_pend = 1'b1;
                next_s.size_ok = size_ok_v;
                next_s.rate_ok = rate_ok_v;
                next_s.scale = scale_v;
                // one display frame per source frame, masked or not
                next_s.disp_frame = (s.st == PVI_ST_RUN);
                next_s.frames = s.frames + 1'b1;
            end
            if (accept) begin
                next_s.pix.valid = 1'b1;
                next_s.pix.sof = s.sof_pend;
                next_s.pix.sol = (lp == '0);
                next_s.pix.eye = ev;
                next_s.pix.data = pvi_unpack(s.ctrl.fmt, pin.bus, cp, s.cb_hold, s.cr_hold);
                next_s.sof_pend = 1'b0;
                next_s.line_pix = lp + 1'b1;
                next_s.cphase = ~cp;
                // chroma alternates blue then red, both sited on the even luma
                if (!cp) begin
                    next_s.cb_hold = pin.bus[7:0];
                end else begin
                    next_s.cr_hold = pin.bus[7:0];
                end
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.ctrl <= pvi_ctrl_t'(`PVI_CTRL_RST);
            s.hstart <= `PVI_HSTART_RST;
            s.hact <= `PVI_HACT_RST;
            s.vstart <= `PVI_VSTART_RST;
            s.vact <= `PVI_VACT_RST;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign pix_out = s.pix;
    assign disp_frame = s.disp_frame;
    assign frame_hold = s.mask_lat;
    assign scale_mode = s.scale;
    assign glasses_sync = s.ctrl.glasses_en & s.eye;
endmodule

// File: design/pvi_sync2.sv
// two-flop synchroniser for a group of pin levels
module pvi_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } pvi_sync_t;

    pvi_sync_t s;
    pvi_sync_t next_s;

    // ==========================================================
    // the first stage feeds only the second
    always_comb begin
        next_s.meta = d;
        next_s.stab = s.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.stab;
endmodule

// File: tb/parallel_video_input_port_test.sv
// self-checking bench for the parallel video input port
module parallel_video_input_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pvi_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gl = 1'b0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, pix_clk, frame_sync, line_sync, pixel_valid_in, eye_select, frame_update_mask;
    logic disp_frame, frame_hold, glasses_sync;
    logic [23:0] pixel_bus;
    pvi_pix_t pix_out;
    pvi_scale_t scale_mode;
    logic [23:0] got_d[$];
    logic [3:0] got_f[$];
    logic [31:0] rv[5] = '{32'h80, 32'h0, 32'h780, 32'h0, 32'h438};
    int n_mismatch = 0, compares = 0, n_frames = 0;

    initial begin
        forever #25 pclk = ~pclk;
    end

    // short period limits suit the tiny test frames
    pvi_port #(.P2D_LO(100), .P2D_HI(4000), .P3D_LO(50), .P3D_HI(2000), .P3D720_HI(1900)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_clk(pix_clk),
        .frame_sync(frame_sync), .line_sync(line_sync), .pixel_valid_in(pixel_valid_in), .pixel_bus(pixel_bus),
        .eye_select(eye_select), .frame_update_mask(frame_update_mask), .pix_out(pix_out),
        .disp_frame(disp_frame), .frame_hold(frame_hold), .scale_mode(scale_mode), .glasses_sync(glasses_sync)
    );
    pvi_src src (
        .pix_clk(pix_clk), .frame_sync(frame_sync), .line_sync(line_sync), .pixel_valid_in(pixel_valid_in),
        .pixel_bus(pixel_bus), .eye_select(eye_select), .frame_update_mask(frame_update_mask)
    );

    // ==========================================================
    // monitor reads pre-edge flop values
    always @(posedge pclk) begin
        if (pix_out.valid === 1'b1) begin
            got_d.push_back(pix_out.data);
            got_f.push_back({pix_out.sof, pix_out.sol, pix_out.eye, glasses_sync});
        end
        if (disp_frame === 1'b1) n_frames++;
    end

    // ==========================================================
    // tasks
    task automatic test_done();
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; read data and error land in q and e
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            test_done();
        end else begin
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // one frame, every pixel checked against the format mapping
    task automatic frame_check(input logic [1:0] f, input logic eye, input logic mask, input int n_exp);
        int nf;
        logic [23:0] b, pr, x, m;
        got_d.delete();
        got_f.delete();
        nf = n_frames;
        src.frame(eye, mask);
        repeat (40) @(posedge pclk);
        check(32'(got_d.size()), 32'(n_exp));
        check(32'(n_frames - nf), 32'h1);
        for (int i = 0; i < n_exp; i++) begin
            b = src.pval(i / 4, i % 4);
            pr = src.pval(i / 4, i % 4 - 1);
            m = (f == 2'h3 && i % 4 == 0) ? 24'h00FFFF : 24'hFFFFFF;
            case (f)
                2'h0: x = b;
                2'h1: x = {b[17:12], b[17:16], b[11:6], b[11:10], b[5:0], b[5:4]};
                2'h2: x = {b[15:11], b[15:13], b[10:5], b[10:9], b[4:0], b[4:2]};
                default: x = (i % 2) ? {b[7:0], b[15:8], pr[7:0]} : {pr[7:0], b[15:8], b[7:0]};
            endcase
            check(32'(got_d[i] & m), 32'(x & m));
            check(32'(got_f[i]), {28'h0, i == 0, i % 4 == 0, eye, eye & gl});
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(q, rv[i]);
        end
        apb(1'b1, 8'h24, 32'hFFFFFFFF);
        check({31'h0, e}, 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        check({q[30:0], e}, 32'h1);
        apb(1'b1, 8'h20, 32'h5);
        apb(1'b0, 8'h20, 32'h0);
        check(q, 32'h0);
        apb(1'b1, 8'h00, 32'h84);
        src.frame(1'b0, 1'b0);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, 8'h00, 32'h84 | 32'(f));
            frame_check(2'(f), 1'b0, 1'b0, 12);
        end
        apb(1'b1, 8'h00, 32'h384);
        gl = 1'b1;
        frame_check(2'h0, 1'b0, 1'b0, 12);
        frame_check(2'h0, 1'b1, 1'b0, 12);
        gl = 1'b0;
        apb(1'b1, 8'h00, 32'h84);
        frame_check(2'h0, 1'b0, 1'b1, 0);
        check({31'h0, frame_hold}, 32'h1);
        frame_check(2'h0, 1'b0, 1'b0, 12);
        apb(1'b1, 8'h00, 32'hC4);
        frame_check(2'h0, 1'b0, 1'b1, 12);
        frame_check(2'h0, 1'b0, 1'b0, 0);
        apb(1'b1, 8'h00, 32'h80);
        src.sync_low = 1'b1;
        src.cap_fall = 1'b1;
        apb(1'b1, 8'h00, 32'hBC);
        src.frame(1'b0, 1'b0);
        frame_check(2'h0, 1'b0, 1'b0, 12);
        apb(1'b1, 8'h04, 32'h8);
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h00, 32'h3C);
        got_d.delete();
        src.frame(1'b0, 1'b0);
        repeat (40) @(posedge pclk);
        check(32'(got_d.size()), 32'h2);
        check(32'(got_d[0]), 32'(src.pval(1, 1)));
        check(32'(got_d[1]), 32'(src.pval(1, 2)));
        test_done();
    end
endmodule

// File: tb/pvi_port_assertions.sv
// concurrent checks on the outputs of the parallel video input port
module pvi_port_assertions (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // apb
    input logic psel,
    input logic penable,
    input logic [7:0] paddr,
    input logic pslverr,
    // video and display
    input logic frame_sync,
    input pvi_pkg::pvi_pix_t pix_out,
    input logic disp_frame,
    input logic frame_hold,
    input pvi_pkg::pvi_scale_t scale_mode,
    input logic glasses_sync
);
    timeunit 1ns;
    timeprecision 1ns;
    import pvi_pkg::*;
    logic fs_q;
    logic [7:0] fs_age;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // helper
    // cycles since the frame sync pin moved, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_q <= 1'b0;
            fs_age <= 8'hFF;
        end else begin
            fs_q <= frame_sync;
            fs_age <= (frame_sync != fs_q) ? 8'h00 : ((fs_age == 8'hFF) ? fs_age : fs_age + 8'h01);
        end
    end

    // ==========================================================
    // assertions
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside an access phase");
    err_unmapped_a: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access without slave error");
    valid_pulse_a: assert property (pix_out.valid |=> !pix_out.valid)
        else $error("pixel strobe longer than one cycle");
    sof_line_a: assert property (pix_out.sof |-> pix_out.valid && pix_out.sol)
        else $error("frame start without line start");
    hold_blocks_a: assert property (frame_hold |-> !pix_out.valid)
        else $error("pixel passed in a held frame");
    hold_at_frame_a: assert property ($changed(frame_hold) |-> fs_age <= 8'h14)
        else $error("hold changed away from a frame sync");
    scale_at_frame_a: assert property ($changed(scale_mode) |-> fs_age <= 8'h14)
        else $error("scale mode changed away from a frame sync");
    frame_pace_a: assert property (disp_frame |-> (fs_age <= 8'h14) ##1 !disp_frame)
        else $error("display frame not paced by the frame sync");
    glasses_eye_a: assert property (pix_out.valid && glasses_sync |-> pix_out.eye)
        else $error("glasses sync disagrees with pixel eye");

    // main scenarios
    cover property (disp_frame);
    cover property (pix_out.sof);
    cover property (frame_hold && disp_frame);
endmodule

bind pvi_port pvi_port_assertions chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
    .frame_sync(frame_sync), .pix_out(pix_out), .disp_frame(disp_frame), .frame_hold(frame_hold),
    .scale_mode(scale_mode), .glasses_sync(glasses_sync)
);

// File: tb/pvi_src.sv
// behavioural video front end driving the port's pixel pins
module pvi_src (
    // source pins
    output logic pix_clk,
    output logic frame_sync,
    output logic line_sync,
    output logic pixel_valid_in,
    output logic [23:0] pixel_bus,
    output logic eye_select,
    output logic frame_update_mask
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sync_low = 1'b0;
    logic cap_fall = 1'b0;
    logic fs_act = 1'b0;
    logic ls_act = 1'b0;

    // ==========================================================
    // clock and idle levels
    // free running 2.5 MHz pixel clock, far below the ceiling of the port
    initial begin
        pix_clk = 1'b0;
        #13;
        forever #200 pix_clk = ~pix_clk;
    end

    // mask tied low until a scenario uses it
    initial begin
        pixel_valid_in = 1'b0;
        pixel_bus = 24'h000000;
        eye_select = 1'b0;
        frame_update_mask = 1'b0;
    end

    // syncs rest at the inactive level of the chosen polarity
    assign frame_sync = fs_act ^ sync_low;
    assign line_sync = ls_act ^ sync_low;

    // ==========================================================
    // frame generation
    function automatic logic [23:0] pval(input int l, input int p);
        return 24'hA5C33C + 24'(l) * 24'h010101 + 24'(p) * 24'h020406;
    endfunction

    // launch on the edge opposite capture so pins are settled when taken
    task automatic tick();
        if (cap_fall) @(posedge pix_clk);
        else @(negedge pix_clk);
    endtask

    // three lines of four pixels; one eye per frame, bounded by frame syncs
    task automatic frame(input logic eye, input logic mask);
        tick();
        eye_select = eye;
        frame_update_mask = mask;
        tick();
        fs_act = 1'b1;
        tick();
        fs_act = 1'b0;
        repeat (2) tick();
        for (int l = 0; l < 3; l++) begin
            ls_act = 1'b1;
            repeat (4) tick();
            ls_act = 1'b0;
            repeat (3) tick();
            for (int p = 0; p < 4; p++) begin
                pixel_valid_in = 1'b1;
                pixel_bus = pval(l, p);
                tick();
            end
            pixel_valid_in = 1'b0;
            pixel_bus = ~pixel_bus; // no stale pixel left on the bus
            repeat (8) tick();
        end
    endtask
endmodule
